// File: core/mfm_pkg.sv
/*
 * constants and helpers for the outgoing multiframe marker input.
 * assumes one system clock; the low-rate clock is a divide-by-four enable.
 */
package mfm_pkg;
    localparam int          NUM_STM1    = 4;
    localparam int          LANE_W      = 2;
    localparam int          PHASE_W     = 2;
    localparam logic [1:0]  DIV_LAST    = 2'h3;   // low-rate enable once every four clocks
    localparam logic [1:0]  DIV_RST     = 2'h0;
    localparam logic [1:0]  PHASE_FIRST = 2'h0;   // multiframe frame one
    localparam logic [1:0]  PHASE_STEP  = 2'h1;
    localparam logic [1:0]  LANE_STM1   = 2'h0;   // single stm-1 sits on lane zero, phase bits 1:0
    localparam logic [3:0]  PEND_RST    = 4'h0;
    localparam logic [7:0]  PHASE_RST   = 8'h00;

    typedef logic [LANE_W-1:0] mfm_lane_type;

    // one-hot decode of an stm-1 index
    function automatic logic [NUM_STM1-1:0] mfm_onehot(input mfm_lane_type idx);
        logic [NUM_STM1-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction
endpackage

// File: core/mfm_tick_if.sv
/*
 * carries the low-rate sample enable from the divider to the marker logic.
 * assumes both ends sit on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface mfm_tick_if;
    logic low_rate_en;
    modport src (output low_rate_en);
    modport dst (input  low_rate_en);
endinterface
`default_nettype wire

// File: core/mfm_rate_div.sv
/*
 * divide-by-four enable generator standing in for the low-rate clock.
 * assumes i_sys_clk is the high-rate clock; enable is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module mfm_rate_div (
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst,
    mfm_tick_if.src     tick
);
    import mfm_pkg::*;

    logic [1:0] cnt_q;

    // free running count, no realignment input
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= DIV_RST;
        end else begin
            cnt_q <= cnt_q + PHASE_STEP;
        end
    end

    // enable registered so it is glitch free
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tick.low_rate_en <= 1'b0;
        end else begin
            tick.low_rate_en <= (cnt_q == DIV_LAST - PHASE_STEP);
        end
    end
endmodule
`default_nettype wire

// File: core/mfm_marker_in.sv
/*
 * outgoing tributary multiframe marker input for the first outgoing stream.
 * assumes byte position strobes and frame start come from the outgoing
 * timing chain, synchronous to i_sys_clk, held for a whole low-rate period
 * in stm-1 mode.
 */
`timescale 1ns/1ps
`default_nettype none
module mfm_marker_in (
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst,
    input  wire logic               i_outgoing_multiframe_marker,
    input  wire logic               i_outgoing_width_select,
    input  wire logic               i_marker_position_select,
    input  wire logic               i_j1_third_byte,
    input  wire logic               i_h4_byte,
    input  wire mfm_pkg::mfm_lane_type i_stm1_index,
    input  wire logic               i_frame_start,
    output logic [3:0]              o_mf_first,
    output logic [7:0]              o_mf_phase,
    output logic [3:0]              o_marker_pending
);
    import mfm_pkg::*;

    mfm_tick_if tick ();

    logic           sample_en;
    logic           pos_ok;
    logic           accept;
    logic           frame_tick;
    mfm_lane_type   lane_w;
    logic [3:0]     set_w;
    logic [3:0]     pending_q;
    logic [3:0]     first_q;
    logic [7:0]     phase_q;

    mfm_rate_div u_div (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .tick      (tick.src)
    );

    // sample rate depends on interface width
    assign sample_en  = i_outgoing_width_select ? tick.low_rate_en : 1'b1;
    // slot qualification, a marker outside the selected slot strobe is ignored
    assign pos_ok     = i_marker_position_select ? i_h4_byte : i_j1_third_byte;
    assign accept     = sample_en & i_outgoing_multiframe_marker & pos_ok;
    // stm-1 mode always lands on lane zero, stm-4 follows the byte's stm-1
    assign lane_w     = i_outgoing_width_select ? LANE_STM1 : i_stm1_index;
    assign set_w      = accept ? mfm_onehot(lane_w) : PEND_RST;
    assign frame_tick = i_frame_start & sample_en;

    // pending realignment per stm-1; a marker seen at frame start wins
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pending_q <= PEND_RST;
        end else if (frame_tick) begin
            pending_q <= set_w;
        end else begin
            pending_q <= pending_q | set_w;
        end
    end

    // multiframe phase per stm-1, reset to frame one on a pending marker
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_q <= PHASE_RST;
            first_q <= PEND_RST;
        end else begin
            first_q <= PEND_RST;
            if (frame_tick) begin
                for (int i = 0; i < NUM_STM1; i++) begin
                    if (pending_q[i]) begin
                        phase_q[i*PHASE_W +: PHASE_W] <= PHASE_FIRST;
                        first_q[i] <= 1'b1;
                    end else begin
                        phase_q[i*PHASE_W +: PHASE_W] <=
                            phase_q[i*PHASE_W +: PHASE_W] + PHASE_STEP;
                    end
                end
            end
        end
    end

    assign o_mf_first       = first_q;
    assign o_mf_phase       = phase_q;
    assign o_marker_pending = pending_q;

    // divider cadence seen as a sequence
    sequence s_div_gap;
        !tick.low_rate_en [*3] ##1 tick.low_rate_en;
    endsequence

    property p_div_period;
        @(posedge i_sys_clk) disable iff (i_rst)
        tick.low_rate_en |=> s_div_gap;
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("low-rate enable not every four clocks");

    property p_stm1_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_outgoing_width_select && !tick.low_rate_en |=> $stable(pending_q);
    endproperty
    a_stm1_hold: assert property (p_stm1_hold)
        else $error("marker state changed between low-rate samples");

    property p_stm1_lane;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_outgoing_width_select |-> set_w[3:1] == 3'h0;
    endproperty
    a_stm1_lane: assert property (p_stm1_lane)
        else $error("stm-1 marker routed off lane zero");

    property p_stm4_lane;
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_outgoing_width_select && i_outgoing_multiframe_marker && pos_ok
            |=> pending_q[$past(i_stm1_index)];
    endproperty
    a_stm4_lane: assert property (p_stm4_lane)
        else $error("stm-4 marker not taken for its stm-1");

    property p_stm4_rate;
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_outgoing_width_select && !tick.low_rate_en && i_outgoing_multiframe_marker && pos_ok
            |=> pending_q != PEND_RST;
    endproperty
    a_stm4_rate: assert property (p_stm4_rate)
        else $error("stm-4 mode not sampling every clock");

    property p_slot_only;
        @(posedge i_sys_clk) disable iff (i_rst)
        !pos_ok && !frame_tick |=> pending_q == $past(pending_q);
    endproperty
    a_slot_only: assert property (p_slot_only)
        else $error("marker taken outside selected slot");

    property p_select_h4;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_marker_position_select && i_outgoing_multiframe_marker && i_h4_byte
            && sample_en && i_outgoing_width_select |=> pending_q[0];
    endproperty
    a_select_h4: assert property (p_select_h4)
        else $error("h4 slot marker not taken");

    property p_active_high;
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_outgoing_multiframe_marker && pending_q == PEND_RST |=> pending_q == PEND_RST;
    endproperty
    a_active_high: assert property (p_active_high)
        else $error("marker taken while input low");

    sequence s_realign;
        first_q[0] && phase_q[1:0] == PHASE_FIRST;
    endsequence

    property p_realign;
        @(posedge i_sys_clk) disable iff (i_rst)
        frame_tick && pending_q[0] |=> s_realign;
    endproperty
    a_realign: assert property (p_realign)
        else $error("accepted marker did not restart multiframe");

    property p_advance;
        @(posedge i_sys_clk) disable iff (i_rst)
        frame_tick && !pending_q[0]
            |=> !first_q[0] && phase_q[1:0] == 2'($past(phase_q[1:0]) + PHASE_STEP);
    endproperty
    a_advance: assert property (p_advance)
        else $error("multiframe phase did not advance");

    // third-byte slot taken when selected, on the lane of the current byte
    property p_j1_select;
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_marker_position_select && i_outgoing_multiframe_marker && i_j1_third_byte
            && sample_en |=> pending_q[$past(lane_w)];
    endproperty
    a_j1_select: assert property (p_j1_select)
        else $error("third byte slot marker not taken");

    // a frame start with no new marker leaves nothing pending
    property p_pending_clear;
        @(posedge i_sys_clk) disable iff (i_rst)
        frame_tick && !accept |=> pending_q == PEND_RST;
    endproperty
    a_pending_clear: assert property (p_pending_clear)
        else $error("pending marker survived a frame start");

    // first-frame flags mirror exactly what was pending at the frame start
    property p_first_lane;
        @(posedge i_sys_clk) disable iff (i_rst)
        frame_tick |=> first_q == $past(pending_q);
    endproperty
    a_first_lane: assert property (p_first_lane)
        else $error("first frame flags differ from pending markers");

    // a first-frame flag only follows a taken frame start
    property p_first_cause;
        @(posedge i_sys_clk) disable iff (i_rst)
        first_q != PEND_RST |-> $past(frame_tick);
    endproperty
    a_first_cause: assert property (p_first_cause)
        else $error("first frame flag without frame start");

    // phases only move on a taken frame start
    property p_phase_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        !frame_tick |=> phase_q == $past(phase_q);
    endproperty
    a_phase_hold: assert property (p_phase_hold)
        else $error("multiframe phase moved without frame start");

    // between low-rate enables no frame start can be taken in stm-1 mode
    property p_stm1_mask;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_outgoing_width_select && !tick.low_rate_en |=> first_q == PEND_RST;
    endproperty
    a_stm1_mask: assert property (p_stm1_mask)
        else $error("stm-1 frame start taken off the low-rate enable");

    // enables are never adjacent, so a stm-1 first flag lasts one clock
    property p_stm1_pulse;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_outgoing_width_select && first_q != PEND_RST |=> first_q == PEND_RST;
    endproperty
    a_stm1_pulse: assert property (p_stm1_pulse)
        else $error("stm-1 first frame flag held past one clock");
endmodule
`default_nettype wire

// File: tb/mfm_upstream.sv
/* upstream payload source model: marker, slot strobes, stm-1 index, frame start.
   assumes calls arrive at a falling edge of i_sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module mfm_upstream (
    input  wire logic             i_sys_clk,
    output logic                  o_marker,
    output logic                  o_j1_third,
    output logic                  o_h4,
    output mfm_pkg::mfm_lane_type o_idx,
    output logic                  o_frame_start
);
    import mfm_pkg::*;
    // idle at time zero: marker low, no slot
    initial begin
        idle();
    end
    // hold one slot n clocks; marker only in clock at, or all when at < 0
    task automatic send(input logic mk, j1, h4, fs, input mfm_lane_type idx,
                        input int n, input int at);
        o_j1_third = j1;
        o_h4 = h4;
        o_idx = idx;
        o_frame_start = fs;
        for (int i = 0; i < n; i++) begin
            o_marker = mk && (at < 0 || at == i);
            @(posedge i_sys_clk);
            @(negedge i_sys_clk);
        end
    endtask
    // no idle in send, so back-to-back slots never assign twice in one step
    task automatic idle();
        {o_marker, o_j1_third, o_h4, o_frame_start} = 4'h0;
        o_idx = LANE_STM1;
    endtask
endmodule
`default_nettype wire

// File: tb/mfm_marker_in_bench.sv
/* self-checking bench for the outgoing multiframe marker input.
   assumes the upstream model drives the marker side, bench sets the modes. */
`timescale 1ns/1ps
`default_nettype none
module mfm_marker_in_bench;
    import mfm_pkg::*;
    logic         i_sys_clk, i_rst, wsel, psel, mk, j1, h4, fs;
    mfm_lane_type idx;
    logic [3:0]   first, pend;
    logic [7:0]   phase;
    int           n_fail, checked, hits, base, first_cnt;
    mfm_upstream up (.i_sys_clk(i_sys_clk), .o_marker(mk), .o_j1_third(j1), .o_h4(h4),
                     .o_idx(idx), .o_frame_start(fs));
    mfm_marker_in dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_outgoing_multiframe_marker(mk),
        .i_outgoing_width_select(wsel), .i_marker_position_select(psel),
        .i_j1_third_byte(j1), .i_h4_byte(h4), .i_stm1_index(idx), .i_frame_start(fs),
        .o_mf_first(first), .o_mf_phase(phase), .o_marker_pending(pend));
    // clock 25 mhz
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // running count of lane-zero first flags; the pulse may land mid-period
    always @(posedge i_sys_clk) first_cnt <= first_cnt + int'(first[0] === 1'b1);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic stm1_h4();
        wsel = 1'b1;
        psel = 1'b1;
        up.send(1, 0, 1, 0, 2'h3, 4, -1);
        check(pend, 4'h1);
        base = first_cnt;
        up.send(0, 0, 0, 1, 2'h0, 4, -1);
        check(8'(first_cnt - base), 8'h01);
        check(phase[1:0], 2'h0);
        check(pend, 4'h0);
    endtask
    task automatic stm1_slot();
        up.send(1, 1, 0, 0, 2'h0, 4, -1);
        check(pend, 4'h0);
        up.send(1, 0, 0, 0, 2'h0, 4, -1);
        check(pend, 4'h0);
        psel = 1'b0;
        up.send(1, 1, 0, 0, 2'h0, 4, -1);
        check(pend, 4'h1);
    endtask
    // one-clock marker at each offset of a slot: only the enable cycle counts
    task automatic stm1_enable();
        hits = 0;
        for (int k = 0; k < 4; k++) begin
            up.send(0, 0, 0, 1, 2'h0, 4, -1);
            up.send(1, 1, 0, 0, 2'h0, 4, k);
            hits += int'(pend[0] === 1'b1);
        end
        check(8'(hits), 8'h01);
    endtask
    task automatic stm4_lanes();
        up.send(0, 0, 0, 1, 2'h0, 4, -1);
        wsel = 1'b0;
        psel = 1'b1;
        up.send(1, 0, 1, 0, 2'h2, 1, -1);
        check(pend, 4'h4);
        up.send(0, 0, 0, 1, 2'h0, 1, -1);
        check(first, 4'h4);
        check(phase[5:4], 2'h0);
        up.send(0, 0, 0, 1, 2'h0, 1, -1);
        check(phase[5:4], 2'h1);
        check(pend, 4'h0);
        for (int l = 0; l < 4; l++) up.send(1, 0, 1, 0, 2'(l), 1, -1);
        check(pend, 4'hf);
        up.send(0, 0, 0, 1, 2'h0, 1, -1);
        check(pend, 4'h0);
        psel = 1'b0;
        up.send(1, 1, 0, 0, 2'h1, 1, -1);
        check(pend, 4'h2);
        up.send(1, 0, 1, 0, 2'h3, 1, -1);
        up.idle();
        check(pend, 4'h2);
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        n_fail++;
        close_out();
    end
    initial begin
        {i_rst, wsel, psel} = 3'b110;
        {n_fail, checked} = '0;
        repeat (10) @(negedge i_sys_clk);
        i_rst = 1'b0;
        @(negedge i_sys_clk);
        stm1_h4();
        stm1_slot();
        stm1_enable();
        stm4_lanes();
        close_out();
    end
endmodule
`default_nettype wire
